// ### logic/tppwm_top.sv
// Behaviour
// - With modulation enabled the two timers form one 8-bit modulator whose waveform drives the timer 1 pin.
// - While enabled, timer 0 is forced into 8-bit auto-reload mode whatever software chose.
// - The prescale reload value sets the division, from none at FFh to 256 at 00h.
// - The prescale counter advances once per machine cycle of twelve clocks.
// - On overflow the prescale counter reloads, so it overflows every 256 minus reload machine cycles.
// - The period counter steps by one on each prescale overflow and never otherwise.
// - The period counter always runs 00h to FFh and wraps; the compare value is never loaded into it.
// - The FFh to 00h wrap of the period counter drives the waveform high, unless the new compare value is 00h.
// - A match of the period counter with the active compare value drives the waveform low.
// - Compare writes sit in a buffer and, while modulating, reach the comparison only at the next wrap.
// - Reading the compare register returns the latest written value at once.
// - The enable is bit 5 of the power control register at address 87H, cleared by reset.
`timescale 1ns/10ps
`default_nettype none
`include "tppwm_params.svh"

module tppwm_top (
    // clock and reset
    input  wire logic                  CLOCK,
    input  wire logic                  RST_N,
    // special function register write port from the core
    input  wire logic                  SFR_WR,
    input  wire tppwm_pkg::tppwm_byte_t SFR_ADDR,
    input  wire tppwm_pkg::tppwm_byte_t SFR_WDATA,
    // prescale reload value held by the core
    input  wire tppwm_pkg::tppwm_byte_t PRESCALE_RELOAD_VALUE,
    // pulse width compare register access
    input  wire logic                  COMPARE_WR,
    input  wire tppwm_pkg::tppwm_byte_t COMPARE_WDATA,
    output var  tppwm_pkg::tppwm_byte_t COMPARE_RDATA,
    // software selected timer modes
    input  wire tppwm_pkg::tppwm_mode_t T0_SW_MODE,
    input  wire tppwm_pkg::tppwm_mode_t T1_SW_MODE,
    // effective timer modes and status
    output var  tppwm_pkg::tppwm_mode_t T0_MODE,
    output var  tppwm_pkg::tppwm_mode_t T1_MODE,
    output var  logic                  MODULATION_ENABLE_BIT,
    output var  tppwm_pkg::tppwm_byte_t PRESCALE_COUNTER,
    output var  tppwm_pkg::tppwm_byte_t PERIOD_COUNTER,
    // waveform output pin
    output var  logic                  WAVEFORM_OUTPUT_PIN,
    output var  logic                  WAVEFORM_OUTPUT_PIN_OE_N
);

    import tppwm_pkg::*;

    logic        mc_tick;
    logic        overflow;
    logic        wrap;
    tppwm_byte_t compare_active;
    tppwm_byte_t next_period;
    tppwm_byte_t next_compare;
    tppwm_wave_t wave;

    function automatic logic at_max(input tppwm_byte_t v);
        at_max = (v == `TPPWM_CNT_MAX);
    endfunction

    // power control register, only the enable bit lives here
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            MODULATION_ENABLE_BIT <= 1'b0;
        end else if (SFR_WR && SFR_ADDR == `TPPWM_PWRCTL_ADDR) begin
            MODULATION_ENABLE_BIT <= SFR_WDATA[`TPPWM_PWRCTL_EN_BIT];
        end
    end

    tppwm_mcdiv u_mcdiv (
        .CLOCK (CLOCK),
        .RST_N (RST_N),
        .run   (MODULATION_ENABLE_BIT),
        .tick  (mc_tick)
    );

    assign overflow = mc_tick && at_max(PRESCALE_COUNTER);
    assign wrap     = overflow && at_max(PERIOD_COUNTER);

    // timer 0 mode forced while modulating, software choice otherwise; timer 1 always software choice
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            T0_MODE <= T0_SW_MODE;
            T1_MODE <= T1_SW_MODE;
        end else if (MODULATION_ENABLE_BIT) begin
            T0_MODE <= `TPPWM_MODE_RELOAD;
            T1_MODE <= T1_SW_MODE;
        end else begin
            T0_MODE <= T0_SW_MODE;
            T1_MODE <= T1_SW_MODE;
        end
    end

    // prescaler, loaded from the reload value while idle so the first
    // period after enabling is already the programmed length
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            PRESCALE_COUNTER <= `TPPWM_CNT_ZERO;
        end else if (!MODULATION_ENABLE_BIT) begin
            PRESCALE_COUNTER <= PRESCALE_RELOAD_VALUE;
        end else if (overflow) begin
            PRESCALE_COUNTER <= PRESCALE_RELOAD_VALUE;
        end else if (mc_tick) begin
            PRESCALE_COUNTER <= PRESCALE_COUNTER + `TPPWM_CNT_ONE;
        end
    end

    // period counter, natural 8-bit wrap, never loaded from compare
    always_comb begin
        next_period = PERIOD_COUNTER + `TPPWM_CNT_ONE;
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N || !MODULATION_ENABLE_BIT) begin
            PERIOD_COUNTER <= `TPPWM_CNT_ZERO;
        end else if (overflow) begin
            PERIOD_COUNTER <= next_period;
        end
    end

    // compare buffer; readback shows the buffer, not the active copy
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            COMPARE_RDATA <= `TPPWM_CNT_ZERO;
        end else if (COMPARE_WR) begin
            COMPARE_RDATA <= COMPARE_WDATA;
        end
    end

    // a write in the wrap cycle itself is taken straight into the new period
    always_comb begin
        next_compare = COMPARE_WR ? COMPARE_WDATA : COMPARE_RDATA;
    end

    // active copy follows the buffer while idle and moves only at the wrap while modulating, to avoid mid-period glitches
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            compare_active <= `TPPWM_CNT_ZERO;
        end else if (!MODULATION_ENABLE_BIT || wrap) begin
            compare_active <= next_compare;
        end
    end

    // waveform: high at wrap, low on match; zero width stays low
    always_ff @(posedge CLOCK) begin
        if (!RST_N || !MODULATION_ENABLE_BIT) begin
            wave <= TPPWM_WAVE_LOW;
        end else if (wrap) begin
            if (next_compare == `TPPWM_CNT_ZERO) begin
                wave <= TPPWM_WAVE_LOW;
            end else begin
                wave <= TPPWM_WAVE_HIGH;
            end
        end else if (overflow && next_period == compare_active) begin
            wave <= TPPWM_WAVE_LOW;
        end
    end

    assign WAVEFORM_OUTPUT_PIN = (wave == TPPWM_WAVE_HIGH);

    // pin released when not modulating
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            WAVEFORM_OUTPUT_PIN_OE_N <= 1'b1;
        end else begin
            WAVEFORM_OUTPUT_PIN_OE_N <= !MODULATION_ENABLE_BIT;
        end
    end

endmodule

`default_nettype wire

// ### logic/tppwm_params.svh
`ifndef TPPWM_PARAMS_SVH
`define TPPWM_PARAMS_SVH

// oscillator clocks per machine cycle, single-speed mode
`define TPPWM_MC_DIV        4'd12
`define TPPWM_MC_LAST       4'd11
`define TPPWM_MC_ZERO       4'd0

// special function address of the power control register
`define TPPWM_PWRCTL_ADDR   8'h87
// modulation enable bit position in that register
`define TPPWM_PWRCTL_EN_BIT 5

// counter limits
`define TPPWM_CNT_MAX       8'hff
`define TPPWM_CNT_ZERO      8'h00
`define TPPWM_CNT_ONE       8'h01

// timer mode codes
`define TPPWM_MODE_RELOAD   2'h2

`endif

// ### logic/tppwm_pkg.sv
package tppwm_pkg;

    typedef logic [7:0] tppwm_byte_t;
    typedef logic [1:0] tppwm_mode_t;

    typedef enum logic {
        TPPWM_WAVE_LOW,
        TPPWM_WAVE_HIGH
    } tppwm_wave_t;

endpackage

// ### logic/tppwm_mcdiv.sv
`timescale 1ns/10ps
`default_nettype none
`include "tppwm_params.svh"

module tppwm_mcdiv (
    // clock and reset
    input  wire logic CLOCK,
    input  wire logic RST_N,
    // control
    input  wire logic run,
    // machine cycle enable
    output var  logic tick
);

    logic [3:0] phase;

    // counter held at zero while idle so the first tick is a full cycle late
    always_ff @(posedge CLOCK) begin
        if (!RST_N || !run) begin
            phase <= `TPPWM_MC_ZERO;
        end else if (phase == `TPPWM_MC_LAST) begin
            phase <= `TPPWM_MC_ZERO;
        end else begin
            phase <= phase + 4'd1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            tick <= 1'b0;
        end else begin
            tick <= run && (phase == `TPPWM_MC_LAST);
        end
    end

endmodule

`default_nettype wire

// ### test/tppwm_chk_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module tppwm_chk
    import tppwm_pkg::*;
(
    input wire logic CLOCK, RST_N, SFR_WR, COMPARE_WR,
    input wire logic MODULATION_ENABLE_BIT, WAVEFORM_OUTPUT_PIN,
    input wire logic WAVEFORM_OUTPUT_PIN_OE_N,
    input wire tppwm_byte_t SFR_ADDR, SFR_WDATA, PRESCALE_RELOAD_VALUE,
    input wire tppwm_byte_t COMPARE_WDATA, COMPARE_RDATA,
    input wire tppwm_byte_t PRESCALE_COUNTER, PERIOD_COUNTER,
    input wire tppwm_mode_t T0_SW_MODE, T1_SW_MODE, T0_MODE, T1_MODE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    logic en;
    assign en = MODULATION_ENABLE_BIT;
    enable_write_a: assert property (SFR_WR && SFR_ADDR == 8'h87
        |=> en == $past(SFR_WDATA[5])) else $error("enable bit");
    t0_forced_a: assert property (1'b1 |=> T0_MODE ==
        ($past(en) ? 2'h2 : $past(T0_SW_MODE))) else $error("t0 mode");
    t1_mode_a: assert property (1'b1
        |=> T1_MODE == $past(T1_SW_MODE)) else $error("t1 mode");
    pin_drive_a: assert property (1'b1
        |=> WAVEFORM_OUTPUT_PIN_OE_N == !$past(en)) else $error("oe");
    idle_low_a: assert property (!en
        |=> !WAVEFORM_OUTPUT_PIN && PERIOD_COUNTER == 8'h00)
        else $error("idle");
    compare_read_a: assert property (COMPARE_WR
        |=> COMPARE_RDATA == $past(COMPARE_WDATA)) else $error("rdata");
    period_step_a: assert property (en && $past(en, 2)
        && $changed(PERIOD_COUNTER) |-> $past(PRESCALE_COUNTER) == 8'hff
        && PERIOD_COUNTER == $past(PERIOD_COUNTER) + 8'h01)
        else $error("period step");
    prescale_step_a: assert property (en && $past(en, 2)
        && $changed(PRESCALE_COUNTER) |-> PRESCALE_COUNTER ==
        ($past(PRESCALE_COUNTER) == 8'hff ? $past(PRESCALE_RELOAD_VALUE)
        : $past(PRESCALE_COUNTER) + 8'h01)) else $error("prescale");
    // only 8 of the 11 quiet cycles are checked, repetition is capped
    tick_gap_a: assert property (en && $changed(PRESCALE_COUNTER)
        |=> ($stable(PRESCALE_COUNTER) || !en) [*8]) else $error("tick");
    wave_rise_a: assert property ($rose(WAVEFORM_OUTPUT_PIN)
        |-> en && PERIOD_COUNTER == 8'h00) else $error("rise");
    cover property ($rose(WAVEFORM_OUTPUT_PIN));
    cover property ($fell(WAVEFORM_OUTPUT_PIN) && en);
    cover property ($rose(WAVEFORM_OUTPUT_PIN_OE_N));
endmodule
bind tppwm_top tppwm_chk chk_u (.*);
`default_nettype wire

// ### test/tppwm_load.sv
`timescale 1ns/10ps
`default_nettype none
module tppwm_load (
    // clock and pin
    input  wire logic        clk,
    input  wire logic        pin,
    input  wire logic        pin_oe_n,
    // seen level and last high time
    output var  logic        lvl,
    output var  logic [15:0] width,
    output var  int          pulses
);
    logic [15:0] run = 16'h0000;
    int          cnt = 0;
    // released pin is pulled down by the load
    assign lvl = !pin_oe_n && pin;
    assign pulses = cnt;
    always_ff @(posedge clk) begin
        if (lvl) begin
            run <= run + 16'h0001;
        end else if (run != 16'h0000) begin
            width <= run;
            cnt   <= cnt + 1;
            run   <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// ### test/timer_pair_pwm_tb.sv
`timescale 1ns/10ps
`default_nettype none
module timer_pair_pwm_tb;
    import tppwm_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, swr = 1'b0, cwr = 1'b0;
    logic en, wave, oe_n, lvl;
    tppwm_byte_t sa = 8'h00, sd = 8'h00, rl = 8'hff, cd = 8'h40;
    tppwm_byte_t crd, pre, per;
    tppwm_mode_t t0s = 2'h1, t1s = 2'h3, t0m, t1m;
    logic [15:0] width;
    int pulses, k, fail_count = 0, checked = 0;
    always #25 clk = ~clk;
    tppwm_top dut_u (.CLOCK(clk), .RST_N(rst_n), .SFR_WR(swr),
        .SFR_ADDR(sa), .SFR_WDATA(sd), .PRESCALE_RELOAD_VALUE(rl),
        .COMPARE_WR(cwr), .COMPARE_WDATA(cd), .COMPARE_RDATA(crd),
        .T0_SW_MODE(t0s), .T1_SW_MODE(t1s), .T0_MODE(t0m), .T1_MODE(t1m),
        .MODULATION_ENABLE_BIT(en), .PRESCALE_COUNTER(pre),
        .PERIOD_COUNTER(per), .WAVEFORM_OUTPUT_PIN(wave),
        .WAVEFORM_OUTPUT_PIN_OE_N(oe_n));
    tppwm_load load_u (.clk(clk), .pin(wave), .pin_oe_n(oe_n), .lvl(lvl),
        .width(width), .pulses(pulses));
    task stop_test;
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task tmo;
        fail_count++;
        $display("unexpected at %0t: timeout", $time);
        stop_test;
    endtask
    task wr(input logic sfr, input tppwm_byte_t a, input tppwm_byte_t d);
        @(posedge clk);
        swr <= sfr;
        cwr <= !sfr;
        sa <= a;
        if (sfr) sd <= d;
        else cd <= d;
        @(posedge clk);
        swr <= 1'b0;
        cwr <= 1'b0;
        #1;
    endtask
    task wait_pulse(input logic [15:0] exp);
        int n;
        n = pulses;
        for (k = 0; k < 13000 && pulses == n; k++) @(posedge clk);
        #1;
        if (pulses == n) tmo;
        chk(width, exp);
    endtask
    task s_reset;
        chk({oe_n, en, wave, crd}, 16'h400);
        chk({pre, per}, 16'h0000);
    endtask
    task s_enable;
        wr(1'b1, 8'h86, 8'h20);
        chk(en, 16'h0);
        wr(1'b0, 8'h00, 8'h40);
        chk(crd, 16'h40);
        wr(1'b1, 8'h87, 8'h20);
        chk(en, 16'h1);
        @(posedge clk);
        #1;
        chk({t0m, t1m}, 16'hb);
        chk({oe_n, pre}, 16'h0ff);
    endtask
    // new width is written while high, so a glitch would show at once
    task s_buffer;
        for (k = 0; k < 9000 && !lvl; k++) @(posedge clk);
        if (!lvl) tmo;
        wr(1'b0, 8'h00, 8'h10);
        chk(crd, 16'h10);
        wait_pulse(16'd768);
        wait_pulse(16'd192);
    endtask
    task s_reload;
        rl <= 8'hfe;
        wait_pulse(16'd384);
    endtask
    task s_disable;
        wr(1'b1, 8'h87, 8'h00);
        @(posedge clk);
        #1;
        chk({oe_n, wave, per}, 16'h200);
        chk(t0m, 16'h1);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        s_reset;
        s_enable;
        s_buffer;
        s_reload;
        s_disable;
        stop_test;
    end
endmodule
`default_nettype wire
